// [rtc_alarm_trim.sv]
// alarm compare, request output, tamper pin control and oscillator trim
// assumes time bytes, second tick, oscillator tick and register strobes
// come from logic on ref_clk; on_battery comes from the supply switch
`timescale 1ns/1ps
`include "rtc_alarm_trim_cfg.svh"
module rtc_alarm_trim #(
  parameter int unsigned ALARM_PULSE_CYCLES = `PULSE_TIME_MS * `REF_CLK_KHZ
) (
  input  wire logic                             ref_clk,
  input  wire logic                             rstn,
  input  wire rtc_alarm_trim_pkg::reg_req_t     reg_req,
  output logic [7:0]                            reg_rdata,
  input  wire rtc_alarm_trim_pkg::time_bytes_t  time_now,
  input  wire logic                             sec_tick,
  input  wire logic                             osc_tick,
  input  wire logic                             on_battery,
  input  wire logic                             tamper_event,
  output logic                                  tamper_detect_out_n,
  output logic                                  tamper_pullup_en,
  output logic [6:0]                            cap_half_pf,
  output logic                                  trim_second,
  output logic                                  alarm_irq_n
);
  import rtc_alarm_trim_pkg::*;

  localparam int unsigned PW = $clog2(ALARM_PULSE_CYCLES + 1);
  localparam logic [PW-1:0] PULSE_LAST = PW'(ALARM_PULSE_CYCLES - 1);
  localparam logic [16:0] OSC_TERM = 17'(`OSC_COUNTS);
  localparam logic [21:0] ONE_COUNT = 22'(`PPM_UNITS);
  localparam logic [21:0] TWO_COUNT = 22'(2 * `PPM_UNITS);

  // control registers
  logic [7:0]       intctl_q;      // pulse mode, alarm enable, freq sel
  logic [7:0]       evctl_q;       // battery gate, pullup disable
  logic [7:0]       atrim_q;       // delta and analog trim
  logic [2:0]       dtrim_q;       // sign and magnitude
  logic             autoclr_q;     // auto clear enable
  logic             flag_q;        // alarm flag
  logic [5:0][7:0]  alarm_q;       // alarm bytes
  logic [7:0]       rdata_q;       // read data

  // battery level synchroniser
  logic             batt_m_q;      // first stage, read by second only
  logic             batt_s_q;      // usable level

  // pulse generator
  pulse_state_t     state_q;
  pulse_state_t     state_d;
  logic [PW-1:0]    pcnt_q;
  logic [PW-1:0]    pcnt_d;

  // digital trim counter
  logic [16:0]      ocnt_q;        // oscillator counts this second
  logic [21:0]      acc_q;         // fractional count accumulator
  logic             tsec_q;        // trimmed second pulse

  // output registers
  logic             irq_n_q;
  logic             det_n_q;
  logic             pull_q;
  logic [6:0]       cap_q;

  // decode
  wire wr_status = reg_req.wr && (reg_req.addr == `ADDR_STATUS);
  wire rd_status = reg_req.rd && (reg_req.addr == `ADDR_STATUS);
  wire wr_int    = reg_req.wr && (reg_req.addr == `ADDR_INTCTL);
  wire wr_ev     = reg_req.wr && (reg_req.addr == `ADDR_EVCTL);
  wire wr_at     = reg_req.wr && (reg_req.addr == `ADDR_ATRIM);
  wire wr_dt     = reg_req.wr && (reg_req.addr == `ADDR_DTRIM);

  // alarm configuration
  wire pulse_mode   = intctl_q[`INT_PULSE_BIT];
  wire alarm_en     = intctl_q[`INT_ALARM_ENABLE_BIT];
  wire fo_on        = |intctl_q[`INT_FO_MSB:0];
  wire alarm_active = alarm_en && !fo_on;

  logic [5:0] field_en;
  logic [5:0] field_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_alarm
      wire wr_this = reg_req.wr &&
                     (reg_req.addr == 8'(`ADDR_ALARM_FIRST + gi));
      // alarm byte storage
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          alarm_q[gi] <= `CTRL_RESET;
        end else if (wr_this) begin
          alarm_q[gi] <= reg_req.wdata;
        end
      end
      assign field_en[gi]  = alarm_q[gi][`MATCH_EN_BIT];
      assign field_hit[gi] = !field_en[gi] ||
        (alarm_q[gi][`MATCH_EN_BIT-1:0] == time_now[gi][`MATCH_EN_BIT-1:0]);
    end
  endgenerate

  // all enabled fields equal, at least one enabled
  wire match_now = (&field_hit) && (|field_en);
  // evaluated on the tick that advanced the time
  wire trig = sec_tick && match_now && alarm_active;

  // auto clear on completed status read
  wire flag_clr = (wr_status && !reg_req.wdata[`ST_ALARM_BIT]) ||
                  (rd_status && autoclr_q);

  // register writes
  // everything resets to zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      intctl_q  <= `CTRL_RESET;
      evctl_q   <= `CTRL_RESET;
      atrim_q   <= `CTRL_RESET;
      dtrim_q   <= 3'h0;
      autoclr_q <= 1'b0;
    end else begin
      if (wr_int)    intctl_q  <= reg_req.wdata;
      if (wr_ev)     evctl_q   <= reg_req.wdata;
      if (wr_at)     atrim_q   <= reg_req.wdata;
      if (wr_dt)     dtrim_q   <= reg_req.wdata[`DT_SIGN_BIT:0];
      if (wr_status) autoclr_q <= reg_req.wdata[`ST_AUTOCLR_BIT];
    end
  end

  // alarm flag: set wins over clear
  // set on every trigger
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (trig) begin
      flag_q <= 1'b1;
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  // read mux, unmapped words read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (reg_req.addr == `ADDR_STATUS) begin
      rd_mux[`ST_AUTOCLR_BIT] = autoclr_q;
      rd_mux[`ST_ALARM_BIT]   = flag_q;
    end else if (reg_req.addr == `ADDR_INTCTL) begin
      rd_mux = intctl_q;
    end else if (reg_req.addr == `ADDR_EVCTL) begin
      rd_mux = evctl_q;
    end else if (reg_req.addr == `ADDR_ATRIM) begin
      rd_mux = atrim_q;
    end else if (reg_req.addr == `ADDR_DTRIM) begin
      rd_mux = {5'h00, dtrim_q};
    end else if (reg_req.addr >= `ADDR_ALARM_FIRST &&
                 reg_req.addr <= 8'(`ADDR_ALARM_FIRST + 5)) begin
      rd_mux = alarm_q[3'(reg_req.addr - `ADDR_ALARM_FIRST)];
    end
  end

  // read data register, updated every cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rdata_q <= 8'h00;
    else       rdata_q <= rd_mux;
  end

  // supply state synchroniser
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      batt_m_q <= 1'b0;
      batt_s_q <= 1'b0;
    end else begin
      batt_m_q <= on_battery;
      batt_s_q <= batt_m_q;
    end
  end

  // pulse generator, restarts on each match
  always_comb begin
    state_d = state_q;
    pcnt_d  = pcnt_q;
    case (state_q)
      P_IDLE: begin
        if (trig && pulse_mode) begin
          state_d = P_LOW;
          pcnt_d  = '0;
        end
      end
      P_LOW: begin
        if (!alarm_active || !pulse_mode) begin
          state_d = P_IDLE;            // configuration withdrawn
        end else if (trig) begin
          pcnt_d  = '0;                // retrigger
        end else if (pcnt_q == PULSE_LAST) begin
          state_d = P_IDLE;
        end else begin
          pcnt_d  = pcnt_q + 1'b1;
        end
      end
      default: state_d = P_IDLE;
    endcase
  end

  // pulse state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= P_IDLE;
      pcnt_q  <= '0;
    end else begin
      state_q <= state_d;
      pcnt_q  <= pcnt_d;
    end
  end

  // single mode holds low while flag stands
  wire std_low = flag_q && alarm_active && !pulse_mode;

  wire det_gate = batt_s_q && evctl_q[`EV_BATDIS_BIT];

  // pin capacitor, half pF units, top bit inverted
  wire [5:0] at_code = atrim_q[`AT_TRIM_MSB:0];
  wire [6:0] cap_base = `CAP_FIXED_HALF +
                        (at_code[5] ? 7'h00 : `CAP_B5_HALF) +
                        {2'b00, at_code[4:0]};
  // battery delta: 00 none, 01 -1, 10 +1, 11 +2 half pF
  wire [1:0] delta = atrim_q[`AT_DELTA_MSB:`AT_DELTA_LSB];
  logic [6:0] cap_d;
  always_comb begin
    cap_d = cap_base;
    if (batt_s_q) begin
      case (delta)
        2'b01:   cap_d = cap_base - 7'h01;
        2'b10:   cap_d = cap_base + 7'h01;
        2'b11:   cap_d = cap_base + 7'h02;
        default: cap_d = cap_base;
      endcase
    end
  end

  // output registers
  // pullup follows disable bit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_n_q <= 1'b1;
      det_n_q <= 1'b1;
      pull_q  <= 1'b1;
      cap_q   <= `CAP_FIXED_HALF + `CAP_B5_HALF;
    end else begin
      irq_n_q <= !(std_low || (state_q == P_LOW));
      det_n_q <= !(tamper_event && !det_gate);
      pull_q  <= !evctl_q[`EV_PULLDIS_BIT];
      cap_q   <= cap_d;
    end
  end

  // magnitude 0 to 60 ppm in 20 ppm steps
  wire [1:0]  ppm_mag = dtrim_q[1:0];
  wire [21:0] acc_add = 22'(ppm_mag * `PPM_STEP * `OSC_COUNTS);
  wire [21:0] acc_sum = acc_q + acc_add;
  wire [1:0]  extra = (acc_sum >= TWO_COUNT) ? 2'd2 :
                      (acc_sum >= ONE_COUNT) ? 2'd1 : 2'd0;
  wire [21:0] acc_next = acc_sum - 22'(extra * `PPM_UNITS);
  // positive shortens the second, negative stretches
  wire [16:0] term = dtrim_q[`DT_SIGN_BIT] ? OSC_TERM + 17'(extra)
                                           : OSC_TERM - 17'(extra);
  wire        sec_end = osc_tick && (ocnt_q >= term - 17'h1);

  // trimmed second divider
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ocnt_q <= 17'h0;
      acc_q  <= 22'h0;
      tsec_q <= 1'b0;
    end else begin
      tsec_q <= sec_end;
      if (sec_end) begin
        ocnt_q <= 17'h0;
        acc_q  <= acc_next;
      end else if (osc_tick) begin
        ocnt_q <= ocnt_q + 17'h1;
      end
    end
  end

  assign reg_rdata           = rdata_q;
  assign alarm_irq_n         = irq_n_q;
  assign tamper_detect_out_n = det_n_q;
  assign tamper_pullup_en    = pull_q;
  assign cap_half_pf         = cap_q;
  assign trim_second         = tsec_q;

  // checks
  sequence s_pulse_trig;
    trig && pulse_mode && !(state_q == P_LOW);
  endsequence

  a_batt_gate_det: assert property (@(posedge ref_clk) disable iff (!rstn)
    det_gate |=> tamper_detect_out_n)
    else $error("tamper output active while gated on battery");

  a_pullup_ctl: assert property (@(posedge ref_clk) disable iff (!rstn)
    $changed(evctl_q[`EV_PULLDIS_BIT]) |=>
      tamper_pullup_en != $past(tamper_pullup_en))
    else $error("pullup did not follow disable bit");

  a_cap_default: assert property (@(posedge ref_clk) disable iff (!rstn)
    (atrim_q == 8'h00) |=> (cap_half_pf == 7'h32))
    else $error("default load not mid scale");

  a_batt_delta: assert property (@(posedge ref_clk) disable iff (!rstn)
    (batt_s_q && delta == 2'b01 && at_code == 6'h00)
      |=> cap_half_pf == 7'h31)
    else $error("battery delta not applied");

  a_trim_term: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ppm_mag == 2'b00 && acc_q == 22'h0) |-> term == 17'd32768)
    else $error("zero trim changed the second");

  a_single_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    (trig && !pulse_mode) |=> flag_q ##1 !alarm_irq_n)
    else $error("single alarm request not low");

  a_pulse_start: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_pulse_trig |=> (state_q == P_LOW) ##1 !alarm_irq_n)
    else $error("pulse not started on match");

  a_pulse_end: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_q == P_LOW && pcnt_q == PULSE_LAST && !trig)
      |=> state_q == P_IDLE ##1 (alarm_irq_n || flag_q))
    else $error("pulse length wrong");

  a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
    trig |=> flag_q)
    else $error("trigger lost");

  a_fo_suppress: assert property (@(posedge ref_clk) disable iff (!rstn)
    fo_on ##1 fo_on |=> alarm_irq_n)
    else $error("alarm fired with frequency output on");

  a_auto_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rd_status && autoclr_q && !trig) |=> !flag_q)
    else $error("auto clear failed");
endmodule

// [rtc_alarm_trim_cfg.svh]
// constants for the alarm and trim control block: offsets, bits, timing
// assumes inclusion by bare name from the package and the design module
`ifndef RTC_ALARM_TRIM_CFG_SVH
`define RTC_ALARM_TRIM_CFG_SVH

// register word addresses
`define ADDR_STATUS      8'h07
`define ADDR_INTCTL      8'h08
`define ADDR_EVCTL       8'h09
`define ADDR_ATRIM       8'h0A
`define ADDR_DTRIM       8'h0B
`define ADDR_ALARM_FIRST 8'h0C

// field positions
`define ST_AUTOCLR_BIT   7
`define ST_ALARM_BIT     4
`define INT_PULSE_BIT    7
`define INT_ALARM_ENABLE_BIT     6
`define INT_FO_MSB       3
`define EV_BATDIS_BIT    7
`define EV_PULLDIS_BIT   6
`define AT_TRIM_MSB      5
`define AT_DELTA_MSB     7
`define AT_DELTA_LSB     6
`define DT_SIGN_BIT      2
`define MATCH_EN_BIT     7

// reset values
`define CTRL_RESET       8'h00

// load capacitance in half picofarad units
`define CAP_FIXED_HALF   7'h12
`define CAP_B5_HALF      7'h20

// timing
`define PULSE_TIME_MS    250
`define REF_CLK_KHZ      20000
`define OSC_COUNTS       32768
`define PPM_STEP         20
`define PPM_UNITS        1000000

`endif

// [rtc_alarm_trim_pkg.sv]
// types shared by the alarm and trim control block
// assumes the constants header sits in the same folder
package rtc_alarm_trim_pkg;
  `include "rtc_alarm_trim_cfg.svh"

  // one register access from the serial front end
  typedef struct packed {
    logic [7:0] addr;   // word address
    logic       wr;     // write strobe, one cycle
    logic       rd;     // completed read strobe, one cycle
    logic [7:0] wdata;  // write data
  } reg_req_t;

  // running time bytes: sec, min, hour, date, month, weekday
  typedef logic [5:0][7:0] time_bytes_t;

  // pulse generator states
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_LOW  = 2'b01
  } pulse_state_t;
endpackage

// [rtc_host_model.sv]
// host model: byte register accesses and alarm request counting
// assumes it shares ref_clk with the alarm block and drives on falling edges
`timescale 1ns/1ps
`include "rtc_alarm_trim_cfg.svh"
module rtc_host_model (
  input  wire logic                         ref_clk,
  output rtc_alarm_trim_pkg::reg_req_t      req,
  input  wire logic [7:0]                   rdata,
  input  wire logic                         irq_n,
  output int                                irq_falls
);
  import rtc_alarm_trim_pkg::*;

  int falls_q = 0;                  // falling edges seen so far

  assign irq_falls = falls_q;

  // idle bus at time zero
  initial begin
    req = '0;
  end

  // count every falling edge of the alarm request
  always @(negedge irq_n) begin
    falls_q <= falls_q + 1;
  end

  // one write strobe for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge ref_clk);
    req.wr = 1'b0;
  endtask

  // completed read; data shows one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge ref_clk);
    req.rd = 1'b0;
    d = rdata;
  endtask

  task automatic ack(input logic autoclr);
    wr(`ADDR_STATUS, {autoclr, 7'h00});
  endtask
endmodule

// [testbench.sv]
// self-checking bench for the alarm and trim block, random with corners
// assumes the design sources and the host model compile first
`timescale 1ns/1ps
`include "rtc_alarm_trim_cfg.svh"
module testbench;
  import rtc_alarm_trim_pkg::*;
  localparam int PULSE = 20;        // short alarm pulse
  logic        ref_clk = 1'b0;      // 20 MHz clock
  logic        rstn = 1'b0;         // async reset
  logic        sec_tick = 1'b0;     // new second strobe
  logic        osc_tick = 1'b0;     // oscillator count
  logic        on_battery = 1'b0;   // battery supply
  logic        tamper_event = 1'b0; // event level
  time_bytes_t time_now = '0;       // running time
  time_bytes_t tm;                  // time to present
  reg_req_t    reg_req;             // host access
  logic [7:0]  reg_rdata, rv;       // read data
  logic [6:0]  cap_half_pf;         // load code
  logic        tamper_detect_out_n, tamper_pullup_en;
  logic        trim_second, alarm_irq_n;
  logic [5:0]  en;                  // enabled fields
  logic [31:0] seed = 32'h4150B48F; // xorshift state
  logic [31:0] v;                   // random word
  int          mismatches = 0, n_tests = 0, irq_falls, n, g;

  always #25 ref_clk = ~ref_clk;

  rtc_alarm_trim #(.ALARM_PULSE_CYCLES(PULSE)) rtc_alarm_trim_inst (
    .ref_clk, .rstn, .reg_req, .reg_rdata, .time_now, .sec_tick,
    .osc_tick, .on_battery, .tamper_event, .tamper_detect_out_n,
    .tamper_pullup_en, .cap_half_pf, .trim_second, .alarm_irq_n);

  rtc_host_model rtc_host_model_inst (.ref_clk, .req(reg_req),
    .rdata(reg_rdata), .irq_n(alarm_irq_n), .irq_falls);

  // xorshift generator
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // pin capacitor in half pF, delta only on battery
  function automatic logic [6:0] cap_exp(logic [7:0] t, logic b);
    logic [6:0] c;
    c = 7'(t[4:0]) + (t[5] ? 7'h00 : 7'h20) + 7'h12;
    if (b && t[7:6] == 2'b01) c = c - 7'h01;
    if (b && t[7]) c = c + 7'(t[7:6]) - 7'h01;
    return c;
  endfunction

  task automatic cyc(int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    rtc_host_model_inst.wr(a, d);
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] d);
    rtc_host_model_inst.rd(a, d);
  endtask

  // present a new time with its second strobe
  task automatic tick(time_bytes_t t);
    @(negedge ref_clk);
    time_now = t;
    sec_tick = 1'b1;
    @(negedge ref_clk);
    sec_tick = 1'b0;
  endtask

  task automatic check(logic [31:0] seen, logic [31:0] exp, string s);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, s);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog over the expected run length
  initial begin
    #(90000 * 50);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    check(cap_half_pf, 7'h32, "cap reset");
    check({tamper_pullup_en, alarm_irq_n}, 2'b11, "out reset");
    for (int a = 7; a < 8'h12; a++) begin
      rd(8'(a), rv);
      check(rv, 8'h00, "reg reset");
    end
    wr(8'h12, 8'hFF);
    rd(8'h12, rv);
    check(rv, 8'h00, "no year byte");
    $display("test reset done");
    // analog trim, corners first
    for (int i = 0; i < 16; i++) begin
      v = (i == 0) ? 32'h20 : (i == 1) ? 32'h1DF : rnd();
      on_battery = v[8];
      wr(`ADDR_ATRIM, v[7:0]);
      cyc(4);
      check(cap_half_pf, cap_exp(v[7:0], v[8]), "cap");
    end
    on_battery = 1'b0;
    $display("test analog trim done");
    // every event control combination
    for (int k = 0; k < 16; k++) begin
      on_battery = k[1];
      tamper_event = k[2];
      wr(`ADDR_EVCTL, {k[0], k[3], 6'h00});
      cyc(3);
      check(tamper_detect_out_n, !(k[2] && !(k[1] && k[0])), "det");
      check(tamper_pullup_en, !k[3], "pullup");
    end
    on_battery = 1'b0;
    tamper_event = 1'b0;
    $display("test event control done");
    // single event alarms on field subsets
    for (int i = 0; i < 6; i++) begin
      en = (i == 0) ? 6'h02 : (i == 1) ? 6'h3F : 6'(rnd()) | 6'h01;
      g = 0;
      for (int f = 5; f >= 0; f--) begin
        v = rnd();
        wr(8'(`ADDR_ALARM_FIRST + f), {en[f], v[6:0]});
        tm[f] = {v[15], en[f] ? v[6:0] : v[14:8]};
        if (en[f]) g = f;
      end
      rd(8'(`ADDR_ALARM_FIRST + g), rv);
      check(rv, {1'b1, tm[g][6:0]}, "alarm byte");
      wr(`ADDR_STATUS, {i[0], 7'h00});
      wr(`ADDR_INTCTL, 8'h40);
      tm[g][0] = ~tm[g][0];
      tick(tm);
      cyc(3);
      check(alarm_irq_n, 1'b1, "early alarm");
      tm[g][0] = ~tm[g][0];
      tick(tm);
      check(alarm_irq_n, 1'b1, "irq latency");
      cyc(1);
      check(alarm_irq_n, 1'b0, "irq on match");
      cyc(PULSE * 2);
      check(alarm_irq_n, 1'b0, "irq held");
      rd(`ADDR_STATUS, rv);
      check(rv[4], 1'b1, "flag set");
      cyc(2);
      check(alarm_irq_n, i[0], "auto clear");
      if (!i[0]) rtc_host_model_inst.ack(1'b0);
      cyc(3);
      check(alarm_irq_n, 1'b1, "irq released");
    end
    wr(`ADDR_INTCTL, 8'h41);
    tick(tm);
    cyc(3);
    check(alarm_irq_n, 1'b1, "freq out blocks");
    $display("test single alarm done");
    // pulse mode, flag not cleared until the final status read
    wr(`ADDR_INTCTL, 8'hC0);
    g = irq_falls;
    for (int p = 0; p < 3; p++) begin
      tick(tm);
      cyc(1);
      n = 0;
      while (alarm_irq_n === 1'b0 && n < 100) begin
        n++;
        cyc(1);
      end
      check(n, PULSE, "pulse width");
    end
    check(irq_falls - g, 3, "pulse count");
    rd(`ADDR_STATUS, rv);
    check(rv[4], 1'b1, "flag pulse");
    $display("test pulse alarm done");
    // digital trim at minus sixty lengthens the second
    wr(`ADDR_DTRIM, 8'h07);
    rd(`ADDR_DTRIM, rv);
    check(rv, 8'h07, "trim read");
    osc_tick = 1'b1;
    for (int s = 0; s < 2; s++) begin
      n = 0;
      do begin
        cyc(1);
        n++;
      end while (trim_second !== 1'b1 && n < 40000);
    end
    check(n >= 32769 && n <= 32770, 1'b1, "trim second");
    $display("test digital trim done");
    conclude();
  end
endmodule
